// ### core/tpf_pkg.sv
// package: constants and types for the test panel force and power stop block
package tpf_pkg;
   localparam int unsigned CLK_HZ          = 100000000;
   // output relays 00..15 and input points 00..19
   localparam int unsigned OUT_NUM         = 16;
   localparam int unsigned IN_NUM          = 20;
   // switch debounce time, microseconds
   localparam int unsigned DEB_TIME_US     = 5000;
   localparam int unsigned DEB_CYCLES      = (CLK_HZ / 1000000) * DEB_TIME_US;
   // one mains cycle, microseconds (50 Hz worst case)
   localparam int unsigned MAINS_CYCLE_US  = 20000;
   localparam int unsigned MAINS_CYCLES    = (CLK_HZ / 1000000) * MAINS_CYCLE_US;
   // event bit positions
   localparam int unsigned EV_LOW          = 0;
   localparam int unsigned EV_FAIL         = 1;
   localparam int unsigned EV_RESTORE      = 2;
   localparam int unsigned EV_ARM          = 3;
   localparam int unsigned EV_NUM          = 4;
   // selector positions
   typedef enum logic [1:0] {
      TPF_SEL_STOP = 2'b00,
      TPF_SEL_RUN  = 2'b01,
      TPF_SEL_PROG = 2'b10
   } tpf_sel_type;
   // supply state machine
   typedef enum logic [1:0] {
      TPF_PWR_OK   = 2'b00,
      TPF_PWR_DIP  = 2'b01,
      TPF_PWR_DOWN = 2'b10
   } tpf_pwr_type;
endpackage

// ### core/tpf_debounce.sv
// debouncer: synchronised switch levels accepted only after a stable interval
`timescale 1ns/1ps
`default_nettype none
module tpf_debounce #(
   parameter int unsigned WIDTH  = 8,
   parameter int unsigned CYCLES = 500000
) (
   // clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             nrst_in,
   // raw and clean switches
   input  wire logic [WIDTH-1:0] raw_in,
   output logic      [WIDTH-1:0] clean_out
);
   localparam int unsigned CW = $clog2(CYCLES + 1);
   if (WIDTH < 1 || CYCLES < 1) begin : g_bad_par
      $error("tpf_debounce: bad parameters");
   end
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic          s1_q, s2_q, cl_q, cl_d;
         logic [CW-1:0] cnt_q, cnt_d;
         always_comb begin
            cl_d  = cl_q;
            cnt_d = '0;
            if (s2_q != cl_q) begin
               cnt_d = cnt_q + CW'(1);
               if (cnt_q == CW'(CYCLES - 1)) begin
                  cl_d  = s2_q;
                  cnt_d = '0;
               end
            end
         end
         always_ff @(posedge sys_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               s1_q  <= 1'b0;
               s2_q  <= 1'b0;
               cl_q  <= 1'b0;
               cnt_q <= '0;
            end else begin
               s1_q  <= raw_in[gi];
               s2_q  <= s1_q;
               cl_q  <= cl_d;
               cnt_q <= cnt_d;
            end
         end
         assign clean_out[gi] = cl_q;
      end
   endgenerate
endmodule
`default_nettype wire

// ### core/tpf_top.sv
// test panel forcing, input substitution, selector limits and supply failure stop
`timescale 1ns/1ps
`default_nettype none
module tpf_top
   import tpf_pkg::*;
#(
   parameter int unsigned DEB_CYC   = tpf_pkg::DEB_CYCLES,
   parameter int unsigned MAINS_CYC = tpf_pkg::MAINS_CYCLES
) (
   // clock and reset
   input  wire logic                         sys_clk_in,
   input  wire logic                         nrst_in,
   // selector and supply monitor
   input  wire tpf_pkg::tpf_sel_type         mode_sel_in,
   input  wire logic                         key_out_in,
   input  wire logic                         supply_ok_in,
   // test panel
   input  wire logic                         panel_present_in,
   input  wire logic                         panel_enable_in,
   input  wire logic                         panel_force_in,
   input  wire logic [tpf_pkg::IN_NUM-1:0]   panel_sw_in,
   // controller side
   input  wire logic [tpf_pkg::IN_NUM-1:0]   ext_in_in,
   input  wire logic [tpf_pkg::OUT_NUM-1:0]  prog_out_in,
   input  wire logic [3:0]                   op_req_in,
   // register port
   input  wire logic [1:0]                   reg_addr_in,
   input  wire logic [7:0]                   reg_wdata_in,
   input  wire logic                         reg_wr_in,
   input  wire logic                         reg_rd_in,
   output logic      [7:0]                   reg_rdata_out,
   // results
   output logic [tpf_pkg::IN_NUM-1:0]        eff_in_out,
   output logic [tpf_pkg::OUT_NUM-1:0]       relay_out,
   output logic                              exec_en_out,
   output logic                              buzzer_out,
   output logic                              panel_active_out,
   output logic [3:0]                        op_grant_out,
   output logic                              irq_out
);
   import tpf_pkg::*;

   localparam int unsigned MW = $clog2(MAINS_CYC + 1);
   localparam logic [1:0] A_STAT = 2'h0;
   localparam logic [1:0] A_CLR  = 2'h1;
   localparam logic [1:0] A_EN   = 2'h2;
   // op request bits: 0 edit, 1 search, 2 monitor, 3 trace
   localparam logic [3:0] OP_VIEW = 4'he;

   if (DEB_CYC < 1 || MAINS_CYC < 1) begin : g_bad_cnt
      $error("tpf_top: counts must be at least one");
   end

   localparam int unsigned DW = IN_NUM + 3;
   logic [DW-1:0] clean;
   tpf_debounce #(
      .WIDTH  (DW),
      .CYCLES (DEB_CYC)
   ) u_deb (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .raw_in     ({panel_present_in, panel_enable_in, panel_force_in, panel_sw_in}),
      .clean_out  (clean)
   );
   logic              pres_c, en_c, force_c;
   logic [IN_NUM-1:0] sw_c;
   assign {pres_c, en_c, force_c, sw_c} = clean;

   // supply state machine
   tpf_pwr_type   pwr_q, pwr_d;
   logic [MW-1:0] dip_q, dip_d;
   always_comb begin
      pwr_d = pwr_q;
      dip_d = '0;
      case (pwr_q)
         TPF_PWR_OK: begin
            if (!supply_ok_in) pwr_d = TPF_PWR_DIP;
         end
         TPF_PWR_DIP: begin
            dip_d = dip_q + MW'(1);
            if (supply_ok_in) pwr_d = TPF_PWR_OK;
            else if (dip_q == MW'(MAINS_CYC - 1)) pwr_d = TPF_PWR_DOWN;
         end
         TPF_PWR_DOWN: begin
            if (supply_ok_in) pwr_d = TPF_PWR_OK;
         end
         default: pwr_d = TPF_PWR_OK;
      endcase
   end
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pwr_q <= TPF_PWR_OK;
         dip_q <= '0;
      end else begin
         pwr_q <= pwr_d;
         dip_q <= dip_d;
      end
   end
   // low supply halts at once; the buzzer sounds for every low sample
   logic halted;
   assign halted = (pwr_q != TPF_PWR_OK) || !supply_ok_in;

   // panel arming: starts disarmed so an enable left on at power up or attach does nothing
   logic arm_q, arm_d, en_prev_q, pres_prev_q;
   always_comb begin
      arm_d = arm_q;
      if (pres_c != pres_prev_q || !pres_c) arm_d = 1'b0;
      else if (en_c && !en_prev_q) arm_d = 1'b1;
      // an off enable disarms until next rising edge
      if (!en_c) arm_d = 1'b0;
   end
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         arm_q       <= 1'b0;
         en_prev_q   <= 1'b1;
         pres_prev_q <= 1'b0;
      end else begin
         arm_q       <= arm_d;
         en_prev_q   <= en_c;
         pres_prev_q <= pres_c;
      end
   end
   logic active;
   assign active = arm_q && en_c && pres_c;

   // outputs and substituted inputs
   logic [OUT_NUM-1:0] relay_d;
   logic [IN_NUM-1:0]  eff_d;
   logic [3:0]         grant_d;
   logic               run_mode, stop_mode;
   assign run_mode  = (mode_sel_in == TPF_SEL_RUN);
   assign stop_mode = (mode_sel_in == TPF_SEL_STOP);
   always_comb begin
      relay_d = '0;
      eff_d   = ext_in_in;
      grant_d = op_req_in;
      if (run_mode && active) eff_d = sw_c;
      // force in stop only; ignored when disabled
      if (run_mode) relay_d = prog_out_in;
      else if (stop_mode && active && force_c) relay_d = sw_c[OUT_NUM-1:0];
      if (stop_mode) grant_d = '0;
      // key out at run keeps view functions only
      else if (run_mode && key_out_in) grant_d = op_req_in & OP_VIEW;
      if (halted) relay_d = '0;
   end

   // status, clear and enable registers; set wins over clear
   logic [EV_NUM-1:0] ev, st_q, st_d, en_q, en_d;
   logic [7:0]        rd_d;
   logic              exec_d, buzz_d, act_d, irq_d;
   assign ev[EV_LOW]     = !supply_ok_in && (pwr_q == TPF_PWR_OK);
   assign ev[EV_FAIL]    = (pwr_d == TPF_PWR_DOWN) && (pwr_q != TPF_PWR_DOWN);
   assign ev[EV_RESTORE] = (pwr_q == TPF_PWR_DOWN) && supply_ok_in;
   assign ev[EV_ARM]     = arm_d && !arm_q;
   always_comb begin
      st_d = st_q;
      en_d = en_q;
      rd_d = 8'h00;
      // status lines are computed here so every output leaves a flop
      exec_d = run_mode && !halted;
      buzz_d = halted;
      act_d  = active;
      if (reg_wr_in && reg_addr_in == A_CLR) st_d = st_q & ~reg_wdata_in[EV_NUM-1:0];
      if (reg_wr_in && reg_addr_in == A_EN) en_d = reg_wdata_in[EV_NUM-1:0];
      st_d = st_d | ev;
      irq_d = |(st_d & en_d);
      if (reg_rd_in) begin
         case (reg_addr_in)
            A_STAT:  rd_d = {2'h0, active, halted, st_q};
            A_EN:    rd_d = {4'h0, en_q};
            default: rd_d = 8'h00;
         endcase
      end
   end
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q             <= '0;
         en_q             <= '0;
         reg_rdata_out    <= 8'h00;
         relay_out        <= '0;
         eff_in_out       <= '0;
         exec_en_out      <= 1'b0;
         buzzer_out       <= 1'b0;
         panel_active_out <= 1'b0;
         op_grant_out     <= '0;
         irq_out          <= 1'b0;
      end else begin
         st_q             <= st_d;
         en_q             <= en_d;
         reg_rdata_out    <= rd_d;
         relay_out        <= relay_d;
         eff_in_out       <= eff_d;
         exec_en_out      <= exec_d;
         buzzer_out       <= buzz_d;
         panel_active_out <= act_d;
         op_grant_out     <= grant_d;
         irq_out          <= irq_d;
      end
   end

   a_relay_halt: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      halted |=> (relay_out == '0 && buzzer_out && !exec_en_out)) else $error("relays not dropped on low supply");
   // dip of one mains cycle stops
   a_dip_stop: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (pwr_q == TPF_PWR_DIP && dip_q == MW'(MAINS_CYC - 1) && !supply_ok_in) |=> pwr_q == TPF_PWR_DOWN)
      else $error("long dip did not stop");
   a_auto_resume: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (pwr_q == TPF_PWR_DOWN && supply_ok_in) |=> pwr_q == TPF_PWR_OK) else $error("no auto resume");
   a_panel_off: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (stop_mode && !en_c) |=> relay_out == '0) else $error("disabled panel forced relays");
   a_force_follow: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (stop_mode && active && force_c && !halted) |=> relay_out == $past(sw_c[OUT_NUM-1:0]))
      else $error("relays do not follow panel");
   a_force_stop: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (run_mode && !halted) |=> relay_out == $past(prog_out_in)) else $error("force acted outside stop");
   // enable held since attach stays inactive
   a_attach_hold: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ($rose(pres_c) && en_c) |=> !arm_q) else $error("panel armed on attach");
   a_arm_edge: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      $rose(arm_q) |-> $past(en_c && !en_prev_q)) else $error("armed without enable edge");
   a_stop_ops: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      stop_mode |=> op_grant_out == 4'h0) else $error("operator function in stop");
   // key out at run keeps view
   a_key_view: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (run_mode && key_out_in) |=> op_grant_out == ($past(op_req_in) & OP_VIEW)) else $error("view lost");
   a_input_sub: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (run_mode && active) |=> eff_in_out == $past(sw_c)) else $error("inputs not substituted");

   // further checks on mode limits, arming, supply dips and the status port
   // program mode drops relays
   a_prog_quiet: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (mode_sel_in == TPF_SEL_PROG) |=> relay_out == '0) else $error("relays driven in program mode");
   a_attach_disarm: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (pres_c != pres_prev_q) |=> !arm_q) else $error("panel armed across attach");
   a_off_disarm: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      !en_c |=> !arm_q) else $error("panel armed with enable off");
   a_stop_exec: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      stop_mode |=> !exec_en_out) else $error("execution enabled in stop");
   // key in at run grants all
   a_key_full: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (run_mode && !key_out_in) |=> op_grant_out == $past(op_req_in)) else $error("operator request lost");
   a_dip_short: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (pwr_q == TPF_PWR_DIP && supply_ok_in) |=> pwr_q == TPF_PWR_OK) else $error("short dip not forgiven");
   a_fail_event: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ev[EV_FAIL] |=> st_q[EV_FAIL]) else $error("stop event lost");
   // running again once supply is back
   a_exec_resume: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (run_mode && !halted) |=> (exec_en_out && !buzzer_out)) else $error("no resume after recovery");
   // inputs external unless panel active in run
   a_input_ext: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      !(run_mode && active) |=> eff_in_out == $past(ext_in_in)) else $error("inputs substituted wrongly");
   a_low_event: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ev[EV_LOW] |=> st_q[EV_LOW]) else $error("low supply event lost");
   // interrupt level follows enabled status
   a_irq_level: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      irq_out == |(st_q & en_q)) else $error("interrupt level wrong");
   // clear write drops only the written bits
   a_clear_stat: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (reg_wr_in && reg_addr_in == A_CLR && ev == '0) |=> st_q == ($past(st_q) & ~$past(reg_wdata_in[EV_NUM-1:0])))
      else $error("status clear wrong");
   // status read data stand one cycle
   a_stat_read: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == A_STAT) |=> reg_rdata_out == {2'h0, $past(active), $past(halted), $past(st_q)})
      else $error("status read wrong");
   // read data return to zero without a read
   a_rdata_idle: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      !reg_rd_in |=> reg_rdata_out == 8'h00) else $error("read data left standing");
endmodule
`default_nettype wire

// ### tb/tpf_panel_model.sv
// partner model: plug-in test panel with its enable, output force and point switches
`timescale 1ns/1ps
`default_nettype none
module tpf_panel_model (
   // operator hands on the switches
   input  wire logic                       attach_in,
   input  wire logic                       en_in,
   input  wire logic                       force_in,
   input  wire logic [tpf_pkg::IN_NUM-1:0] sw_in,
   // connector lines toward the controller
   output logic                            present_out,
   output logic                            enable_out,
   output logic                            force_out,
   output logic [tpf_pkg::IN_NUM-1:0]      sw_out
);
   // unplugged lines float: show the inverse so a stale level cannot pass for a real one
   always_comb begin
      present_out = attach_in;
      enable_out  = attach_in ? en_in : ~en_in;
      force_out   = attach_in ? force_in : ~force_in;
      sw_out      = attach_in ? sw_in : ~sw_in;
   end
endmodule
`default_nettype wire

// ### tb/tpf_top_tb_top.sv
// testbench: panel forcing, selector limits and supply stop of the control block
`timescale 1ns/1ps
`default_nettype none
module tpf_top_tb_top;
   import tpf_pkg::*;
   localparam int unsigned DEB = 4;
   localparam int unsigned MNS = 8;
   logic               sys_clk_in, nrst_in, key_out, supply_ok, attach, en, frc, p_pres, p_en, p_frc;
   logic               wr, rd, exec_en, buzzer, active, irq;
   tpf_sel_type        mode_sel;
   logic [IN_NUM-1:0]  sw, p_sw, ext_in, eff_in;
   logic [OUT_NUM-1:0] prog_out, relay;
   logic [3:0]         op_req, op_grant;
   logic [1:0]         addr;
   logic [7:0]         wdata, rdata, v;
   int                 error_cnt, cmp_count;

   tpf_panel_model panel (.attach_in(attach), .en_in(en), .force_in(frc), .sw_in(sw),
      .present_out(p_pres), .enable_out(p_en), .force_out(p_frc), .sw_out(p_sw));
   tpf_top #(.DEB_CYC(DEB), .MAINS_CYC(MNS)) dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
      .mode_sel_in(mode_sel), .key_out_in(key_out), .supply_ok_in(supply_ok),
      .panel_present_in(p_pres), .panel_enable_in(p_en), .panel_force_in(p_frc), .panel_sw_in(p_sw),
      .ext_in_in(ext_in), .prog_out_in(prog_out), .op_req_in(op_req), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .eff_in_out(eff_in), .relay_out(relay), .exec_en_out(exec_en), .buzzer_out(buzzer),
      .panel_active_out(active), .op_grant_out(op_grant), .irq_out(irq));

   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   // debounce plus sync plus output register, with margin
   task automatic settle();
      cyc(DEB + 8);
   endtask

   task automatic wait_active();
      for (int i = 0; i < 40 && active !== 1'b1; i++) cyc(1);
      if (active !== 1'b1) begin
         error_cnt++;
         final_report();
      end
   endtask

   task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge sys_clk_in);
      wr    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge sys_clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk_in);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   // enable already on through reset must not arm the panel
   task automatic t_rearm();
      settle();
      chk(active, 1'b0);
      @(posedge sys_clk_in) en <= 1'b0;
      settle();
      @(posedge sys_clk_in) en <= 1'b1;
      cyc(2);
      chk(active, 1'b0);
      wait_active();
      chk(active, 1'b1);
   endtask

   // plug in with enable and force already on
   task automatic t_attach();
      @(posedge sys_clk_in) attach <= 1'b0;
      settle();
      chk({active, relay}, 17'h00000);
      @(posedge sys_clk_in) attach <= 1'b1;
      settle();
      chk(active, 1'b0);
      @(posedge sys_clk_in) en <= 1'b0;
      settle();
      @(posedge sys_clk_in) en <= 1'b1;
      wait_active();
      chk(active, 1'b1);
   endtask

   task automatic t_force();
      logic [OUT_NUM-1:0] pats [3] = '{16'h0000, 16'hffff, 16'ha5c3};
      foreach (pats[i]) begin
         @(posedge sys_clk_in) sw <= {4'h9, pats[i]};
         settle();
         chk(relay, pats[i]);
      end
      // force switch off: relays stay off in stop
      @(posedge sys_clk_in) frc <= 1'b0;
      settle();
      chk(relay, 16'h0000);
      @(posedge sys_clk_in) frc <= 1'b1;
      settle();
      chk(relay, 16'ha5c3);
      @(posedge sys_clk_in) en <= 1'b0;
      settle();
      @(posedge sys_clk_in) sw <= ~sw;
      settle();
      chk(relay, 16'h0000);
      @(posedge sys_clk_in) en <= 1'b1;
      wait_active();
      chk(relay, 16'h5a3c);
   endtask

   task automatic t_modes();
      @(posedge sys_clk_in) begin
         mode_sel <= TPF_SEL_RUN;
         prog_out <= 16'h3c5a;
         ext_in   <= 20'h12345;
         sw       <= 20'h0f0f0;
      end
      settle();
      chk(relay, 16'h3c5a);
      chk(eff_in, 20'h0f0f0);
      chk(exec_en, 1'b1);
      // enable off before leaving run for program
      @(posedge sys_clk_in) en <= 1'b0;
      settle();
      chk(eff_in, 20'h12345);
      @(posedge sys_clk_in) mode_sel <= TPF_SEL_PROG;
      settle();
      chk(relay, 16'h0000);
      @(posedge sys_clk_in) begin
         op_req   <= 4'hf;
         mode_sel <= TPF_SEL_STOP;
      end
      cyc(3);
      chk(op_grant, 4'h0);
      @(posedge sys_clk_in) begin
         mode_sel <= TPF_SEL_RUN;
         key_out  <= 1'b1;
      end
      cyc(3);
      chk(op_grant, 4'he);
   endtask

   task automatic t_power();
      reg_wr(2'h2, 8'h0f);
      reg_wr(2'h1, 8'h0f);
      cyc(2);
      chk(irq, 1'b0);
      @(posedge sys_clk_in) supply_ok <= 1'b0;
      cyc(2);
      chk({relay, buzzer, exec_en}, {16'h0000, 2'b10});
      @(posedge sys_clk_in) supply_ok <= 1'b1;
      cyc(6);
      chk({exec_en, buzzer}, 2'b10);
      reg_rd(2'h0, v);
      chk(v[1], 1'b0);
      chk(irq, 1'b1);
      reg_wr(2'h1, 8'h0f);
      @(posedge sys_clk_in) supply_ok <= 1'b0;
      cyc(MNS + 4);
      reg_rd(2'h0, v);
      chk(v[1:0], 2'b11);
      @(posedge sys_clk_in) supply_ok <= 1'b1;
      cyc(6);
      chk({exec_en, relay}, {1'b1, 16'h3c5a});
      // interrupt masked, unmasked, then cleared
      reg_wr(2'h2, 8'h00);
      cyc(2);
      chk(irq, 1'b0);
      reg_wr(2'h2, 8'h0f);
      cyc(2);
      chk(irq, 1'b1);
      reg_wr(2'h1, 8'h0f);
      cyc(2);
      chk(irq, 1'b0);
      reg_rd(2'h0, v);
      chk(v[3:0], 4'h0);
      reg_rd(2'h3, v);
      chk(v, 8'h00);
   endtask

   // power cycled in mid-run with the enable left on
   task automatic t_recycle();
      @(posedge sys_clk_in) en <= 1'b1;
      wait_active();
      @(posedge sys_clk_in) nrst_in <= 1'b0;
      cyc(2);
      chk({active, relay, buzzer}, 18'h00000);
      @(posedge sys_clk_in) nrst_in <= 1'b1;
      settle();
      chk(active, 1'b0);
      @(posedge sys_clk_in) en <= 1'b0;
      settle();
      @(posedge sys_clk_in) en <= 1'b1;
      wait_active();
      chk(active, 1'b1);
   endtask

   initial begin
      error_cnt = 0;
      cmp_count = 0;
      {nrst_in, key_out, wr, rd, addr, wdata, op_req, prog_out, ext_in, sw} = '0;
      {supply_ok, attach, en, frc} = 4'hf;
      mode_sel = TPF_SEL_STOP;
      repeat (4) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      t_rearm();
      t_attach();
      t_force();
      t_modes();
      t_power();
      t_recycle();
      final_report();
   end
endmodule
`default_nettype wire
